// ### rtl/unary_ops_pkg.sv
// Package: opcodes, flag layout, register offsets and cycle counts for the unary/compare unit
package unary_ops_pkg;

  // ---------------------------------------------------------------
  // Opcodes handled here
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_CARRY_INVERT = 8'hef;
  localparam logic [7:0] OP_ZERO_FILL_R = 8'hb0;
  localparam logic [7:0] OP_ZERO_FILL_IND = 8'hb1;
  localparam logic [7:0] OP_INVERT_R = 8'h60;
  localparam logic [7:0] OP_INVERT_IND = 8'h61;
  localparam logic [7:0] OP_COMPARE_RR_W = 8'ha2;
  localparam logic [7:0] OP_COMPARE_RI_W = 8'ha3;
  localparam logic [7:0] OP_COMPARE_RR = 8'ha4;
  localparam logic [7:0] OP_COMPARE_RI = 8'ha5;
  localparam logic [7:0] OP_COMPARE_IMM = 8'ha6;
  localparam logic [7:0] OP_DECREMENT_R = 8'h00;
  localparam logic [7:0] OP_DECREMENT_IND = 8'h01;
  localparam logic [7:0] OP_INTERRUPT_DISABLE = 8'h8f;
  localparam logic [7:0] OP_INTERRUPT_ENABLE = 8'h9f;

  // ---------------------------------------------------------------
  // Flag bit positions inside the condition flag register
  // ---------------------------------------------------------------
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;

  // ---------------------------------------------------------------
  // Register map and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_FLAGS = 8'hd5;
  localparam logic [7:0] ADDR_SYS_MODE = 8'hde;
  localparam int GLOBAL_INT_ENABLE_BIT = 2;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] SYS_MODE_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] OVF_DEC_FROM = 8'h80;

  // ---------------------------------------------------------------
  // Execution timing
  // ---------------------------------------------------------------
  localparam logic [2:0] CYCLES_SHORT = 3'h4;
  localparam logic [2:0] CYCLES_LONG = 3'h6;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01
  } seq_e;

  // Instruction handed over by decode
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] dst;  // Register address or pointer register
    logic [7:0] src;  // Register address or immediate byte
  } instr_s;

  // Register file write request
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } rf_wr_s;

endpackage : unary_ops_pkg

// ### rtl/unary_ops_unit.sv
// Execution unit for carry invert, zero fill, invert, compare, decrement and interrupt enables
//
// Our own choice: strobed register access.
`timescale 1ns/1ns

// ---------------------------------------------------------------
// Overview
// ---------------------------------------------------------------
// An instruction is taken on the edge where issue is high and the unit idles.
// The unit then stays busy for the instruction's full cycle count.
// All results commit together on the last busy edge; done is high in the cycle after it.
// Operands are read combinationally from the register file through two ports.
// Port a fetches a pointer or the source, port b the final destination.
// An indirect compare source fetches its pointer in the first busy cycle,
// so the register file must hold operands steady while the unit is busy.
// Issue while busy is ignored; the decoder must wait for done.
// A software write in the commit cycle is dropped so the result wins.
// Interrupt pins cross two flip-flops before their edge sets a pending bit.
// A pending bit stays set while interrupts are disabled; a set beats a clear.

module unary_ops_unit
  import unary_ops_pkg::*;
#(
  parameter int NUM_IRQ = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic issue,                 // One-cycle start with instr
  input wire instr_s instr,               // Opcode and operand bytes
  output logic busy,                      // Unit is executing
  output logic done,                      // Cycle after an instruction's last busy cycle
  output logic pass_on,                   // Opcode not handled here
  output rf_wr_s rf_wr,                   // Register file write port
  output logic [7:0] rd_addr_a,           // Register file read address a
  input wire logic [7:0] rd_data_a,       // Read data for address a
  output logic [7:0] rd_addr_b,           // Register file read address b
  input wire logic [7:0] rd_data_b,       // Read data for address b
  input wire logic [NUM_IRQ-1:0] irq_in,  // Raw interrupt request pins
  output logic [NUM_IRQ-1:0] pending,     // Latched pending bits
  input wire logic [NUM_IRQ-1:0] pend_clear, // Clear from vectoring logic
  output logic vector_req,                // Request to vector to a handler
  output logic [7:0] flags,               // Condition flag register
  output logic [7:0] sys_mode,            // System mode register
  input wire logic [7:0] reg_addr,        // Software register port address
  input wire logic [7:0] reg_wdata,       // Software write data
  input wire logic reg_wr,                // Software write strobe
  input wire logic reg_rd,                // Software read strobe
  output logic [7:0] reg_rdata            // Read data, cycle after strobe
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  // All registered state of the unit in one word
  typedef struct packed {
    seq_e seq;
    logic [2:0] cnt;
    instr_s cur;
    logic [7:0] ptr;  // Pointer fetched for an indirect compare source
    logic [7:0] flags;
    logic [7:0] sys_mode;
    logic [NUM_IRQ-1:0] irq_s1;
    logic [NUM_IRQ-1:0] irq_s2;
    logic [NUM_IRQ-1:0] irq_d;
    logic [NUM_IRQ-1:0] pending;
    rf_wr_s wr;
    logic done;
    logic pass_on;
    logic [7:0] rdata;
  } state_s;

  state_s st;       // Registered state
  state_s next_st;  // Next state

  // Subtract with flags: returns {borrow, overflow, diff}
  function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] d;
    logic v;
    // Borrow is the ninth bit of the unsigned difference
    d = {1'b0, a} - {1'b0, b};
    // Overflow: signs differ and the result takes the source's sign
    v = (a[7] != b[7]) && (d[7] == b[7]);
    return {d[8], v, d[7:0]};
  endfunction : sub8

  // Cycle count for an opcode
  function automatic logic [2:0] cycles_of(input logic [7:0] op);
    // OP_COMPARE_RR_W is the only compare in the short form
    if (op == OP_COMPARE_RR_W) begin
      return CYCLES_SHORT;
    end
    // Every other compare form needs two more cycles
    if (op inside {OP_COMPARE_RI_W, OP_COMPARE_RR, OP_COMPARE_RI, OP_COMPARE_IMM}) begin
      return CYCLES_LONG;
    end
    return CYCLES_SHORT;
  endfunction : cycles_of

  // Opcode handled by this unit
  function automatic logic is_ours(input logic [7:0] op);
    return op inside {OP_CARRY_INVERT, OP_ZERO_FILL_R, OP_ZERO_FILL_IND, OP_INVERT_R,
                      OP_INVERT_IND, OP_COMPARE_RR_W, OP_COMPARE_RI_W, OP_COMPARE_RR,
                      OP_COMPARE_RI, OP_COMPARE_IMM, OP_DECREMENT_R, OP_DECREMENT_IND,
                      OP_INTERRUPT_DISABLE, OP_INTERRUPT_ENABLE};
  endfunction : is_ours

  // ---------------------------------------------------------------
  // Operand addressing
  // ---------------------------------------------------------------
  logic ind_dst;   // Destination reached through a pointer
  logic ind_src;   // Source reached through a pointer
  logic fetch_ptr; // First busy cycle of an indirect-source compare
  logic [7:0] dst_addr;
  logic [7:0] dst_val;
  logic [7:0] src_val;

  // Read port a fetches the pointer, port b the final operand
  always_comb begin
    ind_dst = st.cur.opcode inside {OP_ZERO_FILL_IND, OP_INVERT_IND, OP_DECREMENT_IND};
    ind_src = st.cur.opcode inside {OP_COMPARE_RI_W, OP_COMPARE_RI};
    fetch_ptr = ind_src && (st.cnt == CYCLES_LONG);
    // Indirect source: pointer register first, then the register it names
    if (ind_dst) begin
      rd_addr_a = st.cur.dst;
    end else if (ind_src && !fetch_ptr) begin
      rd_addr_a = st.ptr;
    end else begin
      rd_addr_a = st.cur.src;
    end
    dst_addr = ind_dst ? rd_data_a : st.cur.dst;
    rd_addr_b = dst_addr;
    dst_val = rd_data_b;
    // Immediate source is the instruction byte itself
    if (st.cur.opcode == OP_COMPARE_IMM) begin
      src_val = st.cur.src;
    end else begin
      src_val = rd_data_a;
    end
  end

  // Compare reads its indirect source in two steps through port a
  logic [7:0] src_final;
  assign src_final = src_val;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [9:0] cmp;
    logic [7:0] res;
    logic last;
    cmp = '0;
    res = '0;
    next_st = st;
    next_st.done = 1'b0;
    next_st.pass_on = 1'b0;
    next_st.wr = '0;
    next_st.rdata = BYTE_ZERO;
    last = (st.seq == ST_BUSY) && (st.cnt == 3'h1);

    // Interrupt pins: two-stage sync, rising edge sets pending; set wins
    next_st.irq_s1 = irq_in;
    next_st.irq_s2 = st.irq_s1;
    next_st.irq_d = st.irq_s2;
    next_st.pending = (st.pending & ~pend_clear) | (st.irq_s2 & ~st.irq_d);

    unique case (st.seq)
      // Idle: take a new instruction or hand it on
      ST_IDLE: begin
        if (issue) begin
          if (is_ours(instr.opcode)) begin
            next_st.seq = ST_BUSY;
            next_st.cur = instr;
            next_st.cnt = cycles_of(instr.opcode);
          end else begin
            next_st.pass_on = 1'b1;
          end
        end
      end
      // Busy: count down, commit everything on the last cycle
      ST_BUSY: begin
        next_st.cnt = st.cnt - 3'h1;
        // Keep the pointer of an indirect compare source for later cycles
        if (fetch_ptr) begin
          next_st.ptr = rd_data_a;
        end
        if (last) begin
          next_st.seq = ST_IDLE;
          next_st.done = 1'b1;
          unique case (st.cur.opcode)
            // Only the carry bit moves
            OP_CARRY_INVERT: begin
              next_st.flags[FLAG_C] = ~st.flags[FLAG_C];
            end
            // Zero to the destination, flags kept
            OP_ZERO_FILL_R, OP_ZERO_FILL_IND: begin
              next_st.wr = '{we: 1'b1, addr: dst_addr, data: BYTE_ZERO};
            end
            // One's complement back to the destination
            OP_INVERT_R, OP_INVERT_IND: begin
              res = ~dst_val;
              next_st.wr = '{we: 1'b1, addr: dst_addr, data: res};
              next_st.flags[FLAG_Z] = (res == BYTE_ZERO);
              next_st.flags[FLAG_S] = res[7];
              next_st.flags[FLAG_V] = 1'b0;
            end
            // Flags only; neither operand is written
            OP_COMPARE_RR_W, OP_COMPARE_RI_W, OP_COMPARE_RR, OP_COMPARE_RI,
            OP_COMPARE_IMM: begin
              cmp = sub8(dst_val, src_final);
              next_st.flags[FLAG_C] = cmp[9];
              next_st.flags[FLAG_Z] = (cmp[7:0] == BYTE_ZERO);
              next_st.flags[FLAG_S] = cmp[7];
              next_st.flags[FLAG_V] = cmp[8];
            end
            // Destination minus one; carry, D and H kept
            OP_DECREMENT_R, OP_DECREMENT_IND: begin
              res = dst_val - 8'h01;
              next_st.wr = '{we: 1'b1, addr: dst_addr, data: res};
              next_st.flags[FLAG_Z] = (res == BYTE_ZERO);
              next_st.flags[FLAG_S] = res[7];
              next_st.flags[FLAG_V] = (dst_val == OVF_DEC_FROM);
            end
            // Global enable off; pending bits keep latching
            OP_INTERRUPT_DISABLE: begin
              next_st.sys_mode[GLOBAL_INT_ENABLE_BIT] = 1'b0;
            end
            // Global enable on; latched requests vector at once
            OP_INTERRUPT_ENABLE: begin
              next_st.sys_mode[GLOBAL_INT_ENABLE_BIT] = 1'b1;
            end
            // Cannot be reached: only handled opcodes enter busy
            default: begin
            end
          endcase
        end
      end
      // Unused state codes fall back to idle
      default: begin
        next_st.seq = ST_IDLE;
      end
    endcase

    // Software port: writes land except in the last busy cycle of any instruction
    if (reg_wr && !last) begin
      if (reg_addr == ADDR_FLAGS) begin
        next_st.flags = reg_wdata;
      end else if (reg_addr == ADDR_SYS_MODE) begin
        next_st.sys_mode = reg_wdata;
      end
    end
    // Read data stands one cycle; unmapped reads give zero
    if (reg_rd) begin
      if (reg_addr == ADDR_FLAGS) begin
        next_st.rdata = st.flags;
      end else if (reg_addr == ADDR_SYS_MODE) begin
        next_st.rdata = st.sys_mode;
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '{seq: ST_IDLE, cnt: 3'h0, cur: '0, ptr: 8'h00, flags: FLAGS_RESET,
              sys_mode: SYS_MODE_RESET, irq_s1: '0, irq_s2: '0, irq_d: '0,
              pending: '0, wr: '0, done: 1'b0, pass_on: 1'b0, rdata: BYTE_ZERO};
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Handshake and data outputs come straight from the state word
  assign busy = (st.seq == ST_BUSY);
  assign done = st.done;
  assign pass_on = st.pass_on;
  assign rf_wr = st.wr;
  assign flags = st.flags;
  assign sys_mode = st.sys_mode;
  assign pending = st.pending;
  assign reg_rdata = st.rdata;
  // Vector only when enabled; pending held while disabled
  assign vector_req = st.sys_mode[GLOBAL_INT_ENABLE_BIT] && (|st.pending);

endmodule : unary_ops_unit

// ### tb/cpu_unary_compare_int_ops_bench.sv
// Bench: instructions and register port accesses with expected results
`timescale 1ns/1ns
module cpu_unary_compare_int_ops_bench
  import unary_ops_pkg::*;
;
  logic clk = 0, rst = 1, issue = 0, reg_wr = 0, reg_rd = 0, busy, done, pass_on, vector_req;
  instr_s instr = 24'h000000;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rd_addr_a, rd_addr_b, flags, sys_mode;
  logic [7:0] irq_in = 8'h00, pend_clear = 8'h00, pending, reg_rdata, fb, r, op;
  logic [7:0] dv [4] = '{8'h02, 8'h80, 8'h05, 8'h7f};
  logic [7:0] sv [4] = '{8'h03, 8'h01, 8'h05, 8'hff};
  rf_wr_s rf_wr;
  logic [7:0] rf [256];  // Register file model, read combinationally
  int bad_count = 0, samples_checked = 0, cycles = 0;
  always #20 clk = ~clk;
  unary_ops_unit #(.NUM_IRQ(8)) DUT (.clk, .rst, .issue, .instr, .busy, .done, .pass_on,
    .rf_wr, .rd_addr_a, .rd_data_a(rf[rd_addr_a]), .rd_addr_b, .rd_data_b(rf[rd_addr_b]),
    .irq_in, .pending, .pend_clear, .vector_req, .flags, .sys_mode, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata);
  always @(posedge clk) begin
    if (rf_wr.we === 1'b1) rf[rf_wr.addr] <= rf_wr.data;
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : check
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wreg
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask : rchk
  // Issue one instruction, wait for done, let the write land
  task automatic run(input logic [7:0] o, input logic [7:0] d, input logic [7:0] s);
    fb = flags;
    @(posedge clk);
    issue <= 1'b1;
    instr <= {o, d, s};
    @(posedge clk);
    issue <= 1'b0;
    #1;
    for (int i = 0; i < 12 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
  endtask : run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rchk(ADDR_FLAGS, FLAGS_RESET);
    rchk(ADDR_SYS_MODE, SYS_MODE_RESET);
    rchk(8'h10, 8'h00);
    wreg(ADDR_FLAGS, 8'h7c);
    run(OP_CARRY_INVERT, 8'h00, 8'h00);
    check(flags, 8'hfc);
    run(OP_CARRY_INVERT, 8'h00, 8'h00);
    rchk(ADDR_FLAGS, 8'h7c);
    $display("test carry invert finished");
    rf[5] = 8'h4f;
    rf[1] = 8'h02;
    rf[2] = 8'h5e;
    run(OP_ZERO_FILL_R, 8'h05, 8'h00);
    check(rf[5], 8'h00);
    run(OP_ZERO_FILL_IND, 8'h01, 8'h00);
    check(rf[2], 8'h00);
    check(rf[1], 8'h02);
    check(flags, 8'h7c);
    $display("test zero fill finished");
    rf[7] = 8'hff;
    rf[1] = 8'h07;
    run(OP_INVERT_R, 8'h07, 8'h00);
    check(rf[7], 8'h00);
    check(flags, 8'h4c);
    run(OP_INVERT_IND, 8'h01, 8'h00);
    check(rf[7], 8'hff);
    check(flags, 8'h2c);
    $display("test invert finished");
    for (int k = 0; k < 4; k++) begin
      for (op = 8'ha2; op <= 8'ha6; op++) begin
        rf[3] = dv[k];
        rf[4] = sv[k];
        rf[8] = 8'h04;  // Pointer to the source for the indirect forms
        r = dv[k] - sv[k];
        run(op, 8'h03, (op == 8'ha6) ? sv[k] : op[0] ? 8'h08 : 8'h04);
        check(rf[8], 8'h04);
        check(flags, {sv[k] > dv[k], r == 8'h00, r[7], dv[k][7] != sv[k][7] && r[7] == sv[k][7],
                      fb[3:0]});
        check(rf[3], dv[k]);
        check(rf[4], sv[k]);
      end
    end
    $display("test compare finished");
    for (int k = 0; k < 4; k++) begin
      rf[1] = 8'h03;
      rf[3] = dv[k] ^ 8'h82;
      r = rf[3] - 8'h01;
      run(k[0] ? OP_DECREMENT_IND : OP_DECREMENT_R, k[0] ? 8'h01 : 8'h03, 8'h00);
      check(rf[3], r);
      check(flags, {fb[7], r == 8'h00, r[7], r == 8'h7f, fb[3:0]});
    end
    $display("test decrement finished");
    run(OP_INTERRUPT_ENABLE, 8'h00, 8'h00);
    rchk(ADDR_SYS_MODE, 8'h04);
    check(flags, fb);
    run(OP_INTERRUPT_DISABLE, 8'h00, 8'h00);
    check(sys_mode, 8'h00);
    check(flags, fb);
    @(posedge clk);
    irq_in <= 8'h08;
    repeat (5) @(posedge clk);
    #1 check(pending, 8'h08);
    check({7'h00, vector_req}, 8'h00);
    run(OP_INTERRUPT_ENABLE, 8'h00, 8'h00);
    check({7'h00, vector_req}, 8'h01);
    @(posedge clk);
    pend_clear <= 8'h08;
    irq_in <= 8'h00;
    repeat (2) @(posedge clk);
    pend_clear <= 8'h00;
    #1 check(pending, 8'h00);
    check({7'h00, vector_req}, 8'h00);
    $display("test interrupt enable finished");
    fb = flags;
    @(posedge clk);
    issue <= 1'b1;
    instr <= {8'h20, 8'h03, 8'h00};
    @(posedge clk);
    issue <= 1'b0;
    #1 check({7'h00, pass_on}, 8'h01);
    r = rf[3];
    repeat (8) @(posedge clk);
    #1 check(flags, fb);
    check(rf[3], r);
    check(sys_mode, 8'h04);
    $display("test pass on finished");
    end_sim();
  end
endmodule : cpu_unary_compare_int_ops_bench

// ### tb/unary_ops_unit_assertions.sv
// Checker: timing and flag relations of the unary/compare unit
`timescale 1ns/1ns
module unary_ops_checker
  import unary_ops_pkg::*;
#(
  parameter int NUM_IRQ = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic issue,
  input wire instr_s instr,
  input wire logic busy,
  input wire logic done,
  input wire logic pass_on,
  input wire rf_wr_s rf_wr,
  input wire logic [7:0] flags,
  input wire logic [7:0] sys_mode,
  input wire logic [NUM_IRQ-1:0] pending,
  input wire logic vector_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Opcode of the instruction in flight
  logic [7:0] op;
  wire take = issue && !busy;
  wire known = instr.opcode inside {8'hef, 8'hb0, 8'hb1, 8'h60, 8'h61, [8'ha2:8'ha6],
                                    8'h00, 8'h01, 8'h8f, 8'h9f};
  wire longop = instr.opcode inside {[8'ha3:8'ha6]};
  wire [7:0] d = rf_wr.data;
  // Latch the opcode when an instruction is taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op <= 8'h00;
    end else if (take) begin
      op <= instr.opcode;
    end
  end
  sequence s_short;
    busy [*4] ##1 (done && !busy);
  endsequence
  sequence s_long;
    busy [*6] ##1 (done && !busy);
  endsequence
  chk_short_timing: assert property (take && known && !longop |=> s_short)
    else $error("four cycle instruction timing wrong");
  chk_long_timing: assert property (take && longop |=> s_long)
    else $error("six cycle compare timing wrong");
  chk_carry_flip: assert property (done && op == 8'hef |-> flags == ($past(flags) ^ 8'h80))
    else $error("carry invert result wrong");
  chk_clear_zero: assert property (done && op[7:1] == 7'h58 |->
    rf_wr.we && d == 8'h00 && $stable(flags))
    else $error("zero fill result wrong");
  chk_invert_flags: assert property (done && op[7:1] == 7'h30 |->
    flags[7:2] == {$past(flags[7]), d == 8'h00, d[7], 1'b0, $past(flags[3:2])})
    else $error("invert flags wrong");
  chk_compare_quiet: assert property (done && op inside {[8'ha2:8'ha6]} |->
    !rf_wr.we && flags[3:2] == $past(flags[3:2]))
    else $error("compare wrote an operand or flag");
  chk_decrement_flags: assert property (done && op[7:1] == 7'h00 |->
    flags[7:2] == {$past(flags[7]), d == 8'h00, d[7], d == 8'h7f, $past(flags[3:2])})
    else $error("decrement flags wrong");
  chk_gie_clear: assert property (done && op == 8'h8f |-> !sys_mode[2] && $stable(flags))
    else $error("interrupt disable wrong");
  chk_gie_set: assert property (done && op == 8'h9f |-> sys_mode[2] && $stable(flags))
    else $error("interrupt enable wrong");
  chk_vector_gate: assert property (vector_req == (sys_mode[2] && (|pending)))
    else $error("vector request not gated by enable");
  chk_pass_on: assert property (take && !known |=> pass_on && !rf_wr.we && $stable(flags))
    else $error("unhandled opcode not passed on");
endmodule : unary_ops_checker

bind unary_ops_unit unary_ops_checker #(.NUM_IRQ(NUM_IRQ)) chk (.clk(clk), .rst(rst),
  .issue(issue), .instr(instr), .busy(busy), .done(done), .pass_on(pass_on), .rf_wr(rf_wr),
  .flags(flags), .sys_mode(sys_mode), .pending(pending), .vector_req(vector_req));
